/* common/pcie_vendor_cfg_regs.svh */
// Offsets, field positions, reset values and write mask of the vendor config bank
`ifndef PCIE_VENDOR_CFG_REGS_SVH
`define PCIE_VENDOR_CFG_REGS_SVH

`define OFF_PRODUCT_DATA_WINDOW 8'hA0
`define OFF_VENDOR_CAP_HEADER 8'hA4
`define OFF_TEST_CONTROL_WORD_0 8'hA8
`define OFF_TEST_CONTROL_WORD_1 8'hAC
`define OFF_LINK_TIMER_OVERRIDE 8'hB0

`define VENDOR_CAP_ID 8'h09
`define VENDOR_CAP_NEXT_PTR 8'hC4
`define VENDOR_CAP_LENGTH 16'h000C
`define TEST_CONTROL_WORD_0_RST 32'h04001060
`define TEST_CONTROL_WORD_1_RST 32'h04000800

`define REPLAY_VALUE_LSB 0
`define REPLAY_VALUE_MSB 11
`define REPLAY_EN_BIT 12
`define PM_CAP_DIS_BIT 13
`define MSI_CAP_DIS_BIT 14
`define AER_CAP_DIS_BIT 15
`define ACK_VALUE_LSB 16
`define ACK_VALUE_MSB 29
`define ACK_EN_BIT 30
`define VGA_CAP_EN_BIT 31

`define LINK_TIMER_RW_MASK 32'h7FFF1FFF
`define LINK_TIMER_RST 32'h80000000

`define FLAG_READ 1'b0
`define FLAG_WRITE 1'b1

`endif

/* common/pcie_vendor_cfg_pkg.sv */
// Types shared by the vendor config bank files
package pcie_vendor_cfg_pkg;
    typedef enum logic [1:0] {
        PD_IDLE,
        PD_BUSY,
        PD_DONE
    } pd_state_e;
    typedef logic [31:0] word_t;
    typedef logic [5:0] pd_addr_t;
endpackage

/* verilog/product_data_port.sv */
// Product-data window engine toward the EEPROM table
`timescale 1ns/100ps
`default_nettype none
`include "pcie_vendor_cfg_regs.svh"
module product_data_port (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic flag_i,
    input wire pcie_vendor_cfg_pkg::pd_addr_t addr_i,
    input wire pcie_vendor_cfg_pkg::word_t wdata_i,
    input wire logic wr_window_i,
    input wire logic ee_done_i,
    input wire pcie_vendor_cfg_pkg::word_t ee_rdata_i,
    output logic ee_req_o,
    output logic ee_we_o,
    output pcie_vendor_cfg_pkg::pd_addr_t ee_addr_o,
    output pcie_vendor_cfg_pkg::word_t ee_wdata_o,
    output pcie_vendor_cfg_pkg::word_t window_o,
    output logic flag_o
);
    pcie_vendor_cfg_pkg::pd_state_e state_q;
    pcie_vendor_cfg_pkg::word_t window_q;
    logic flag_q;
    logic req_q;
    logic we_q;
    pcie_vendor_cfg_pkg::pd_addr_t addr_q;
    wire logic launch = (state_q == pcie_vendor_cfg_pkg::PD_IDLE) && start_i;
    wire logic finish = (state_q == pcie_vendor_cfg_pkg::PD_BUSY) && ee_done_i;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= pcie_vendor_cfg_pkg::PD_IDLE;
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= 6'h00;
        end else begin
            case (state_q)
                pcie_vendor_cfg_pkg::PD_IDLE: begin
                    if (launch) begin
                        state_q <= pcie_vendor_cfg_pkg::PD_BUSY;
                        req_q <= 1'b1;
                        we_q <= flag_i;
                        addr_q <= addr_i;
                    end
                end
                pcie_vendor_cfg_pkg::PD_BUSY: begin
                    req_q <= 1'b0;
                    if (finish) begin
                        state_q <= pcie_vendor_cfg_pkg::PD_DONE;
                    end
                end
                pcie_vendor_cfg_pkg::PD_DONE: begin
                    state_q <= pcie_vendor_cfg_pkg::PD_IDLE;
                end
                default: begin
                    state_q <= pcie_vendor_cfg_pkg::PD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            window_q <= 32'h00000000;
            flag_q <= `FLAG_READ;
        end else if (finish) begin
            flag_q <= ~we_q;
            if (!we_q) begin
                window_q <= ee_rdata_i;
            end
        end else if (launch) begin
            flag_q <= flag_i;
        end else if (wr_window_i) begin
            window_q <= wdata_i;
        end
    end

    assign ee_req_o = req_q;
    assign ee_we_o = we_q;
    assign ee_addr_o = addr_q;
    assign ee_wdata_o = window_q;
    assign window_o = window_q;
    assign flag_o = flag_q;
endmodule
`default_nettype wire

/* verilog/cfg_read_mux.sv */
// Read-data selection across the vendor config bank
`timescale 1ns/100ps
`default_nettype none
`include "pcie_vendor_cfg_regs.svh"
module cfg_read_mux (
    input wire logic [7:0] addr_i,
    input wire logic upstream_i,
    input wire pcie_vendor_cfg_pkg::word_t window_i,
    input wire pcie_vendor_cfg_pkg::word_t test0_i,
    input wire pcie_vendor_cfg_pkg::word_t test1_i,
    input wire pcie_vendor_cfg_pkg::word_t timer_i,
    output pcie_vendor_cfg_pkg::word_t rdata_o,
    output logic hit_o
);
    wire logic hit_window = (addr_i == `OFF_PRODUCT_DATA_WINDOW) && upstream_i;
    wire logic hit_header = (addr_i == `OFF_VENDOR_CAP_HEADER);
    wire logic hit_test0 = (addr_i == `OFF_TEST_CONTROL_WORD_0);
    wire logic hit_test1 = (addr_i == `OFF_TEST_CONTROL_WORD_1);
    wire logic hit_timer = (addr_i == `OFF_LINK_TIMER_OVERRIDE);
    wire pcie_vendor_cfg_pkg::word_t header = {`VENDOR_CAP_LENGTH, `VENDOR_CAP_NEXT_PTR,
        `VENDOR_CAP_ID};

    assign hit_o = hit_window | hit_header | hit_test0 | hit_test1 | hit_timer;
    assign rdata_o = hit_window ? window_i :
                     hit_header ? header :
                     hit_test0 ? test0_i :
                     hit_test1 ? test1_i :
                     hit_timer ? timer_i : 32'h00000000;
endmodule
`default_nettype wire

/* verilog/pcie_vendor_cfg_regs.sv */
// Vendor configuration register bank of one switch port
`timescale 1ns/100ps
`default_nettype none
`include "pcie_vendor_cfg_regs.svh"
module pcie_vendor_cfg_regs (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic UPSTREAM_I,
    input wire logic CFG_RD_I,
    input wire logic CFG_WR_I,
    input wire logic [7:0] CFG_ADDR_I,
    input wire logic [3:0] CFG_BE_I,
    input wire logic [31:0] CFG_WDATA_I,
    output logic [31:0] CFG_RDATA_O,
    output logic CFG_HIT_O,
    input wire logic PD_START_I,
    input wire logic PD_FLAG_I,
    input wire logic [5:0] PD_ADDR_I,
    output logic PD_FLAG_O,
    output logic EE_REQ_O,
    output logic EE_WE_O,
    output logic [5:0] EE_ADDR_O,
    output logic [31:0] EE_WDATA_O,
    input wire logic EE_DONE_I,
    input wire logic [31:0] EE_RDATA_I,
    input wire logic PRELOAD_WR_I,
    input wire logic PRELOAD_EE_I,
    input wire logic [31:0] PRELOAD_DATA_I,
    input wire logic [11:0] AUTO_REPLAY_I,
    input wire logic [13:0] AUTO_ACK_I,
    output logic [11:0] REPLAY_LIMIT_O,
    output logic [13:0] ACK_LIMIT_O,
    output logic PM_CAP_HIDE_O,
    output logic MSI_CAP_HIDE_O,
    output logic AER_CAP_HIDE_O,
    output logic VGA_CAP_EN_O
);
    pcie_vendor_cfg_pkg::word_t test0_q;
    pcie_vendor_cfg_pkg::word_t test1_q;
    pcie_vendor_cfg_pkg::word_t timer_q;
    pcie_vendor_cfg_pkg::word_t timer_d;
    pcie_vendor_cfg_pkg::word_t rdata_q;
    logic hit_q;
    logic [11:0] replay_q;
    logic [13:0] ack_q;
    logic [2:0] hide_q;
    logic vga_q;
    logic pd_flag_q;
    logic ee_req_q;
    logic ee_we_q;
    logic [5:0] ee_addr_q;
    pcie_vendor_cfg_pkg::word_t ee_wdata_q;
    pcie_vendor_cfg_pkg::word_t window;
    pcie_vendor_cfg_pkg::word_t rdata_mux;
    pcie_vendor_cfg_pkg::word_t timer_view;
    logic hit_mux;
    logic flag_w;
    logic req_w;
    logic we_w;
    logic [5:0] eaddr_w;
    pcie_vendor_cfg_pkg::word_t ewdata_w;

    function automatic pcie_vendor_cfg_pkg::word_t merge_be(
        input pcie_vendor_cfg_pkg::word_t old_v,
        input pcie_vendor_cfg_pkg::word_t new_v,
        input logic [3:0] be
    );
        pcie_vendor_cfg_pkg::word_t r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire logic wr_window = CFG_WR_I && UPSTREAM_I
        && (CFG_ADDR_I == `OFF_PRODUCT_DATA_WINDOW);
    wire logic wr_test0 = CFG_WR_I && (CFG_ADDR_I == `OFF_TEST_CONTROL_WORD_0);
    wire logic wr_test1 = CFG_WR_I && (CFG_ADDR_I == `OFF_TEST_CONTROL_WORD_1);
    wire logic wr_timer = CFG_WR_I && (CFG_ADDR_I == `OFF_LINK_TIMER_OVERRIDE);
    wire pcie_vendor_cfg_pkg::word_t timer_cfg = merge_be(timer_q, CFG_WDATA_I, CFG_BE_I);
    wire pcie_vendor_cfg_pkg::word_t window_wdata = merge_be(window, CFG_WDATA_I, CFG_BE_I);
    wire logic vga_next = PRELOAD_EE_I ? PRELOAD_DATA_I[`VGA_CAP_EN_BIT]
        : timer_q[`VGA_CAP_EN_BIT];

    // Software reaches RW fields only; EEPROM preload reaches all fields, register preload all but the VGA bit
    always_comb begin
        timer_d = timer_q;
        if (PRELOAD_WR_I || PRELOAD_EE_I) begin
            timer_d = PRELOAD_DATA_I;
            timer_d[`VGA_CAP_EN_BIT] = vga_next;
        end else if (wr_timer) begin
            timer_d = (timer_cfg & `LINK_TIMER_RW_MASK)
                | (timer_q & ~`LINK_TIMER_RW_MASK);
        end
    end

    assign timer_view = timer_q;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            timer_q <= `LINK_TIMER_RST;
        end else begin
            timer_q <= timer_d;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            test0_q <= `TEST_CONTROL_WORD_0_RST;
            test1_q <= `TEST_CONTROL_WORD_1_RST;
        end else begin
            if (wr_test0) begin
                test0_q <= merge_be(test0_q, CFG_WDATA_I, CFG_BE_I);
            end
            if (wr_test1) begin
                test1_q <= merge_be(test1_q, CFG_WDATA_I, CFG_BE_I);
            end
        end
    end

    product_data_port u_pd (
        .clk_i(MCLK_I),
        .arst_n_i(ARST_N_I),
        .start_i(PD_START_I && UPSTREAM_I),
        .flag_i(PD_FLAG_I),
        .addr_i(PD_ADDR_I),
        .wdata_i(window_wdata),
        .wr_window_i(wr_window),
        .ee_done_i(EE_DONE_I),
        .ee_rdata_i(EE_RDATA_I),
        .ee_req_o(req_w),
        .ee_we_o(we_w),
        .ee_addr_o(eaddr_w),
        .ee_wdata_o(ewdata_w),
        .window_o(window),
        .flag_o(flag_w)
    );

    cfg_read_mux u_mux (
        .addr_i(CFG_ADDR_I),
        .upstream_i(UPSTREAM_I),
        .window_i(window),
        .test0_i(test0_q),
        .test1_i(test1_q),
        .timer_i(timer_view),
        .rdata_o(rdata_mux),
        .hit_o(hit_mux)
    );

    // Registered read answer and link-timer selections
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_q <= 32'h00000000;
            hit_q <= 1'b0;
            replay_q <= 12'h000;
            ack_q <= 14'h0000;
            hide_q <= 3'h0;
            vga_q <= 1'b1;
        end else begin
            rdata_q <= CFG_RD_I ? rdata_mux : 32'h00000000;
            hit_q <= (CFG_RD_I || CFG_WR_I) && hit_mux;
            replay_q <= timer_d[`REPLAY_EN_BIT]
                ? timer_d[`REPLAY_VALUE_MSB:`REPLAY_VALUE_LSB] : AUTO_REPLAY_I;
            ack_q <= timer_d[`ACK_EN_BIT]
                ? timer_d[`ACK_VALUE_MSB:`ACK_VALUE_LSB] : AUTO_ACK_I;
            hide_q <= {timer_d[`AER_CAP_DIS_BIT], timer_d[`MSI_CAP_DIS_BIT],
                timer_d[`PM_CAP_DIS_BIT]};
            vga_q <= timer_d[`VGA_CAP_EN_BIT];
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pd_flag_q <= `FLAG_READ;
            ee_req_q <= 1'b0;
            ee_we_q <= 1'b0;
            ee_addr_q <= 6'h00;
            ee_wdata_q <= 32'h00000000;
        end else begin
            pd_flag_q <= flag_w;
            ee_req_q <= req_w;
            ee_we_q <= we_w;
            ee_addr_q <= eaddr_w;
            ee_wdata_q <= ewdata_w;
        end
    end

    assign CFG_RDATA_O = rdata_q;
    assign CFG_HIT_O = hit_q;
    assign REPLAY_LIMIT_O = replay_q;
    assign ACK_LIMIT_O = ack_q;
    assign PM_CAP_HIDE_O = hide_q[0];
    assign MSI_CAP_HIDE_O = hide_q[1];
    assign AER_CAP_HIDE_O = hide_q[2];
    assign VGA_CAP_EN_O = vga_q;
    assign PD_FLAG_O = pd_flag_q;
    assign EE_REQ_O = ee_req_q;
    assign EE_WE_O = ee_we_q;
    assign EE_ADDR_O = ee_addr_q;
    assign EE_WDATA_O = ee_wdata_q;
endmodule
`default_nettype wire

/* tb/pcie_vendor_cfg_regs_monitor.sv */
// Port checker for the vendor config bank
`timescale 1ns/100ps
`default_nettype none
module pcie_vendor_cfg_regs_monitor (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic UPSTREAM_I,
    input wire logic CFG_RD_I,
    input wire logic CFG_WR_I,
    input wire logic [7:0] CFG_ADDR_I,
    input wire logic [3:0] CFG_BE_I,
    input wire logic [31:0] CFG_WDATA_I,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic CFG_HIT_O,
    input wire logic PD_FLAG_I,
    input wire logic [5:0] PD_ADDR_I,
    input wire logic PD_FLAG_O,
    input wire logic EE_REQ_O,
    input wire logic EE_WE_O,
    input wire logic [5:0] EE_ADDR_O,
    input wire logic EE_DONE_I,
    input wire logic PRELOAD_WR_I,
    input wire logic PRELOAD_EE_I,
    input wire logic [31:0] PRELOAD_DATA_I,
    input wire logic [11:0] AUTO_REPLAY_I,
    input wire logic [13:0] AUTO_ACK_I,
    input wire logic [11:0] REPLAY_LIMIT_O,
    input wire logic [13:0] ACK_LIMIT_O,
    input wire logic PM_CAP_HIDE_O,
    input wire logic MSI_CAP_HIDE_O,
    input wire logic AER_CAP_HIDE_O,
    input wire logic VGA_CAP_EN_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    wire logic no_pre = !PRELOAD_WR_I && !PRELOAD_EE_I;
    wire logic wr_b0 = CFG_WR_I && CFG_ADDR_I == 8'hB0 && CFG_BE_I == 4'hF && no_pre;
    property p_id_read;
        CFG_RD_I && CFG_ADDR_I == 8'hA4 |=> CFG_HIT_O && CFG_RDATA_O == 32'h000CC409;
    endproperty
    a_id_read: assert property (p_id_read) else $error("header read wrong");
    property p_win_down;
        CFG_RD_I && CFG_ADDR_I == 8'hA0 && !UPSTREAM_I |=> !CFG_HIT_O && CFG_RDATA_O == 32'h0;
    endproperty
    a_win_down: assert property (p_win_down) else $error("window on downstream");
    property p_replay;
        wr_b0 |=> REPLAY_LIMIT_O == ($past(CFG_WDATA_I[12]) ? $past(CFG_WDATA_I[11:0])
            : $past(AUTO_REPLAY_I));
    endproperty
    a_replay: assert property (p_replay) else $error("replay limit wrong");
    property p_ack;
        wr_b0 |=> ACK_LIMIT_O == ($past(CFG_WDATA_I[30]) ? $past(CFG_WDATA_I[29:16])
            : $past(AUTO_ACK_I));
    endproperty
    a_ack: assert property (p_ack) else $error("ack limit wrong");
    property p_vga;
        !PRELOAD_EE_I [*2] |=> $stable(VGA_CAP_EN_O);
    endproperty
    a_vga: assert property (p_vga) else $error("vga bit moved");
    property p_hide;
        no_pre [*2] |=> $stable({PM_CAP_HIDE_O, MSI_CAP_HIDE_O, AER_CAP_HIDE_O});
    endproperty
    a_hide: assert property (p_hide) else $error("hide bits moved");
    property p_pre_hide;
        PRELOAD_WR_I ##1 no_pre |=>
            {AER_CAP_HIDE_O, MSI_CAP_HIDE_O, PM_CAP_HIDE_O} == $past(PRELOAD_DATA_I[15:13], 2);
    endproperty
    a_pre_hide: assert property (p_pre_hide) else $error("preload lost");
    property p_flag;
        EE_DONE_I |-> ##2 PD_FLAG_O == !$past(EE_WE_O, 2);
    endproperty
    a_flag: assert property (p_flag) else $error("flag not flipped");
    property p_req;
        EE_REQ_O |-> EE_ADDR_O == $past(PD_ADDR_I, 2) && EE_WE_O == $past(PD_FLAG_I, 2);
    endproperty
    a_req: assert property (p_req) else $error("table request wrong");
    c_rd_done: cover property (EE_DONE_I && !EE_WE_O);
    c_wr_req: cover property (EE_REQ_O && EE_WE_O);
    c_ee_pre: cover property (PRELOAD_EE_I);
endmodule
bind pcie_vendor_cfg_regs pcie_vendor_cfg_regs_monitor u_mon (.MCLK_I, .ARST_N_I, .UPSTREAM_I,
    .CFG_RD_I, .CFG_WR_I, .CFG_ADDR_I, .CFG_BE_I, .CFG_WDATA_I, .CFG_RDATA_O, .CFG_HIT_O,
    .PD_FLAG_I, .PD_ADDR_I, .PD_FLAG_O, .EE_REQ_O, .EE_WE_O, .EE_ADDR_O, .EE_DONE_I,
    .PRELOAD_WR_I, .PRELOAD_EE_I, .PRELOAD_DATA_I, .AUTO_REPLAY_I, .AUTO_ACK_I,
    .REPLAY_LIMIT_O, .ACK_LIMIT_O, .PM_CAP_HIDE_O, .MSI_CAP_HIDE_O, .AER_CAP_HIDE_O,
    .VGA_CAP_EN_O);
`default_nettype wire

/* tb/pcie_vendor_cfg_regs_tb.sv */
// Self-checking bench for the vendor config bank
`timescale 1ns/100ps
`default_nettype none
module pcie_vendor_cfg_regs_tb;
    logic MCLK_I, ARST_N_I, UPSTREAM_I, CFG_RD_I, CFG_WR_I, CFG_HIT_O, PD_START_I, PD_FLAG_I;
    logic PD_FLAG_O, EE_REQ_O, EE_WE_O, EE_DONE_I, PRELOAD_WR_I, PRELOAD_EE_I, hit;
    logic PM_CAP_HIDE_O, MSI_CAP_HIDE_O, AER_CAP_HIDE_O, VGA_CAP_EN_O;
    logic [7:0] CFG_ADDR_I;
    logic [3:0] CFG_BE_I;
    logic [31:0] CFG_WDATA_I, CFG_RDATA_O, EE_WDATA_O, EE_RDATA_I, PRELOAD_DATA_I, rd;
    logic [5:0] PD_ADDR_I, EE_ADDR_O;
    logic [11:0] AUTO_REPLAY_I, REPLAY_LIMIT_O;
    logic [13:0] AUTO_ACK_I, ACK_LIMIT_O;
    int fails, checked;
    pcie_vendor_cfg_regs DUT (.MCLK_I, .ARST_N_I, .UPSTREAM_I, .CFG_RD_I, .CFG_WR_I,
        .CFG_ADDR_I, .CFG_BE_I, .CFG_WDATA_I, .CFG_RDATA_O, .CFG_HIT_O, .PD_START_I,
        .PD_FLAG_I, .PD_ADDR_I, .PD_FLAG_O, .EE_REQ_O, .EE_WE_O, .EE_ADDR_O, .EE_WDATA_O,
        .EE_DONE_I, .EE_RDATA_I, .PRELOAD_WR_I, .PRELOAD_EE_I, .PRELOAD_DATA_I,
        .AUTO_REPLAY_I, .AUTO_ACK_I, .REPLAY_LIMIT_O, .ACK_LIMIT_O, .PM_CAP_HIDE_O,
        .MSI_CAP_HIDE_O, .AER_CAP_HIDE_O, .VGA_CAP_EN_O);
    initial begin
        MCLK_I = 1'h0;
        forever #10 MCLK_I = ~MCLK_I;
    end
    task complete_run;
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick;
        @(posedge MCLK_I);
        #1;
    endtask
    task cfg(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        tick();
        CFG_RD_I = !wr;
        CFG_WR_I = wr;
        CFG_ADDR_I = a;
        CFG_BE_I = be;
        CFG_WDATA_I = d;
        tick();
        CFG_RD_I = 1'h0;
        CFG_WR_I = 1'h0;
        CFG_WDATA_I = ~d;
        rd = CFG_RDATA_O;
        hit = CFG_HIT_O;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic h);
        cfg(1'h0, a, 4'hF, 32'h0);
        chk(rd, exp);
        chk({31'h0, hit}, {31'h0, h});
    endtask
    task preload(input logic ee, input logic [31:0] d);
        tick();
        PRELOAD_EE_I = ee;
        PRELOAD_WR_I = !ee;
        PRELOAD_DATA_I = d;
        tick();
        PRELOAD_EE_I = 1'h0;
        PRELOAD_WR_I = 1'h0;
        PRELOAD_DATA_I = ~d;
        repeat (2) tick();
    endtask
    task pd_cycle(input logic f, input logic [5:0] a, input logic [31:0] d);
        int n;
        tick();
        PD_START_I = 1'h1;
        PD_FLAG_I = f;
        PD_ADDR_I = a;
        tick();
        PD_START_I = 1'h0;
        PD_FLAG_I = !f;
        PD_ADDR_I = ~a;
        n = 0;
        while (EE_REQ_O !== 1'h1 && n < 20) begin
            tick();
            n++;
        end
        chk(n, 1);
        chk({31'h0, EE_WE_O}, {31'h0, f});
        chk({26'h0, EE_ADDR_O}, {26'h0, a});
        if (f) chk(EE_WDATA_O, d);
        tick();
        EE_DONE_I = 1'h1;
        EE_RDATA_I = f ? ~d : d;
        tick();
        EE_DONE_I = 1'h0;
        EE_RDATA_I = ~d;
        tick();
        chk({31'h0, PD_FLAG_O}, {31'h0, !f});
    endtask
    task t_reset;
        rdchk(8'hA4, 32'h000CC409, 1'h1);
        rdchk(8'hA8, 32'h04001060, 1'h1);
        rdchk(8'hAC, 32'h04000800, 1'h1);
        rdchk(8'hB0, 32'h80000000, 1'h1);
        rdchk(8'hB4, 32'h0, 1'h0);
        chk({REPLAY_LIMIT_O, ACK_LIMIT_O}, {12'hABC, 14'h1234});
    endtask
    task t_writes;
        cfg(1'h1, 8'hA4, 4'hF, 32'hFFFFFFFF);
        rdchk(8'hA4, 32'h000CC409, 1'h1);
        cfg(1'h1, 8'hA8, 4'h5, 32'hAABBCCDD);
        rdchk(8'hA8, 32'h04BB10DD, 1'h1);
        cfg(1'h1, 8'hAC, 4'hF, 32'h12345678);
        rdchk(8'hAC, 32'h12345678, 1'h1);
        cfg(1'h1, 8'hB0, 4'hF, 32'hFFFFFFFF);
        chk({REPLAY_LIMIT_O, ACK_LIMIT_O}, {12'hFFF, 14'h3FFF});
        rdchk(8'hB0, 32'hFFFF1FFF, 1'h1);
        cfg(1'h1, 8'hB0, 4'hF, 32'h0);
        chk({REPLAY_LIMIT_O, ACK_LIMIT_O}, {12'hABC, 14'h1234});
    endtask
    task t_preload;
        preload(1'h1, 32'h0);
        chk({28'h0, VGA_CAP_EN_O, AER_CAP_HIDE_O, MSI_CAP_HIDE_O, PM_CAP_HIDE_O}, 32'h0);
        preload(1'h0, 32'hFFFFFFFF);
        chk({28'h0, VGA_CAP_EN_O, AER_CAP_HIDE_O, MSI_CAP_HIDE_O, PM_CAP_HIDE_O}, 32'h7);
        rdchk(8'hB0, 32'h7FFFFFFF, 1'h1);
        preload(1'h1, 32'h80000000);
        rdchk(8'hB0, 32'h80000000, 1'h1);
    endtask
    task t_window;
        pd_cycle(1'h0, 6'h05, 32'hCAFEF00D);
        rdchk(8'hA0, 32'hCAFEF00D, 1'h1);
        UPSTREAM_I = 1'h0;
        cfg(1'h1, 8'hA0, 4'hF, 32'h11111111);
        rdchk(8'hA0, 32'h0, 1'h0);
        tick();
        PD_START_I = 1'h1;
        tick();
        PD_START_I = 1'h0;
        repeat (2) tick();
        chk({31'h0, EE_REQ_O}, 32'h0);
        UPSTREAM_I = 1'h1;
        rdchk(8'hA0, 32'hCAFEF00D, 1'h1);
        cfg(1'h1, 8'hA0, 4'hF, 32'h13572468);
        pd_cycle(1'h1, 6'h3A, 32'h13572468);
        rdchk(8'hA0, 32'h13572468, 1'h1);
    endtask
    initial begin
        #20000;
        fails++;
        complete_run();
    end
    initial begin
        ARST_N_I = 1'h0;
        UPSTREAM_I = 1'h1;
        {CFG_RD_I, CFG_WR_I, PD_START_I, PD_FLAG_I, EE_DONE_I, PRELOAD_WR_I, PRELOAD_EE_I} = 7'h0;
        CFG_ADDR_I = 8'h0;
        CFG_BE_I = 4'h0;
        CFG_WDATA_I = 32'h0;
        PD_ADDR_I = 6'h0;
        EE_RDATA_I = 32'h0;
        PRELOAD_DATA_I = 32'h0;
        AUTO_REPLAY_I = 12'hABC;
        AUTO_ACK_I = 14'h1234;
        repeat (8) tick();
        ARST_N_I = 1'h1;
        t_reset();
        t_writes();
        t_preload();
        t_window();
        complete_run();
    end
endmodule
`default_nettype wire
